//--- inc/fer_cfg.svh
// timing, code-group and reset constants for the receive coding path
`ifndef FER_CFG_SVH
`define FER_CFG_SVH

`define FER_CLK_MHZ 10
`define FER_HOLD_US 722
`define FER_LINKUP_US 395
`define FER_SIGDET_NS 2000
`define FER_NS_PER_US 1000

`define FER_GROUP_BITS 5
`define FER_LOCK_IDLES 12
`define FER_HOLD_IDLE_BITS 58
`define FER_IDLE_RUN_BITS 10
`define FER_JK_TAIL_BITS 7

`define FER_CG_JK 10'h311
`define FER_CG_IDLE 5'h1f
`define FER_CG_T 5'h0d
`define FER_CG_R 5'h07

`define FER_NIB_PRE 4'h5
`define FER_NIB_BAD 4'he
`define FER_NIB_ZERO 4'h0

`define FER_LFSR_W 11
`define FER_LFSR_TAP_A 10
`define FER_LFSR_TAP_B 8
`define FER_LFSR_RST 11'h000

`define FER_WORD_W 6
`define FER_FIFO_DEPTH 8
`define FER_FCC_W 16

`endif

//--- inc/fer_pkg.sv
// types shared by the receive coding path
package fer_pkg;
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CARRIER,
        FR_FRAME,
        FR_BAD
    } fer_frame_e;

    typedef logic [4:0] fer_group_t;
    typedef logic [3:0] fer_nib_t;
endpackage

//--- rtl/fer_fifo.sv
// small nibble FIFO with registered read data
`timescale 1ns/1ps

module fer_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic wr;
    logic load;

    // depth must be a power of two so the pointers wrap on their own
    assign in_ready = (cnt != FULL);
    assign wr = in_valid & in_ready;
    assign load = (cnt != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (wr) begin
                wp <= wp + 1'b1;
            end
            if (load) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(wr) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data <= mem[rp];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

//--- rtl/fer_rx_pcs.sv
// 100 Mb/s receive coding path: nrzi, descrambler, alignment, decoder, link monitor
`timescale 1ns/1ps
`include "fer_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - link pulses alone never raise signal detect
// - receive steps paced by recovered line clock
// - nrzi to nrz, feeding descrambler or alignment
// - five-bit symbols passed to receive state machine
// - plain bit is scrambled bit xor sequence
// - lock after twelve consecutive idle code-groups
// - hold timer restarts after 58 idle bits
// - hold timer expiry drops lock, reacquires
// - alignment fed by descrambler or nrz bypass
// - start delimiter pair fixes code-group boundary
// - start pair after idles becomes two 0101
// - table decode until end pair or idles
// - coding disabled until link is stable
// - link up after 395 us signal detect
// - non-idle without start pair is bad start
// - bad start gives error and 1110 nibbles
// - each bad start adds one to counter
// - two idles end error and carrier sense
// - control code-groups inside frame flag error
// - end pair is 01101 then 00111
// - descrambler and decoder each have bypass
module fer_rx_pcs #(
    parameter int HOLD_CYCLES = `FER_HOLD_US * `FER_CLK_MHZ,
    parameter int LINKUP_CYCLES = `FER_LINKUP_US * `FER_CLK_MHZ,
    parameter int SIGDET_CYCLES =
        (`FER_SIGDET_NS * `FER_CLK_MHZ + `FER_NS_PER_US - 1) / `FER_NS_PER_US,
    parameter int FIFO_DEPTH = `FER_FIFO_DEPTH,
    parameter int FCC_W = `FER_FCC_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_clk,
    input wire logic line_data,
    input wire logic line_energy,
    input wire logic descr_bypass,
    input wire logic dec_bypass,
    input wire logic mac_ready,
    output logic rx_valid,
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic crs,
    output logic link_up,
    output logic tx_enable,
    output logic scr_locked,
    output logic overrun,
    output logic [FCC_W-1:0] false_carrier_event_counter
);
    localparam int WW = `FER_WORD_W;
    localparam int LOCK_BITS = `FER_LOCK_IDLES * `FER_GROUP_BITS;
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int LW = $clog2(LINKUP_CYCLES + 1);
    localparam int SW = $clog2(SIGDET_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES - 1);
    localparam logic [LW-1:0] LINKUP_LAST = LW'(LINKUP_CYCLES - 1);
    localparam logic [SW-1:0] SIGDET_LAST = SW'(SIGDET_CYCLES - 1);
    localparam logic [6:0] LOCK_LAST = 7'(LOCK_BITS - 1);
    localparam logic [5:0] HOLD_IDLE_LAST = 6'(`FER_HOLD_IDLE_BITS - 1);
    localparam logic [3:0] IDLE_RUN = 4'(`FER_IDLE_RUN_BITS);
    localparam logic [2:0] TAIL_LAST = 3'(`FER_JK_TAIL_BITS - 1);
    localparam logic [2:0] GROUP_LAST = 3'(`FER_GROUP_BITS - 1);

    // data table: returns {valid, nibble}; control and violation codes are invalid
    function automatic logic [4:0] fer_dec5(input fer_pkg::fer_group_t g);
        logic [4:0] r;
        r = {1'b0, `FER_NIB_BAD};
        case (g)
            5'h1e: r = {1'b1, 4'h0};
            5'h09: r = {1'b1, 4'h1};
            5'h14: r = {1'b1, 4'h2};
            5'h15: r = {1'b1, 4'h3};
            5'h0a: r = {1'b1, 4'h4};
            5'h0b: r = {1'b1, 4'h5};
            5'h0e: r = {1'b1, 4'h6};
            5'h0f: r = {1'b1, 4'h7};
            5'h12: r = {1'b1, 4'h8};
            5'h13: r = {1'b1, 4'h9};
            5'h16: r = {1'b1, 4'ha};
            5'h17: r = {1'b1, 4'hb};
            5'h1a: r = {1'b1, 4'hc};
            5'h1b: r = {1'b1, 4'hd};
            5'h1c: r = {1'b1, 4'he};
            5'h1d: r = {1'b1, 4'hf};
            default: r = {1'b0, `FER_NIB_BAD};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers

    logic rst_a;
    logic rst_n;
    logic [2:0] in_s1;
    logic [2:0] in_s2;
    logic lclk_d;
    logic bit_en;
    logic line_bit;
    logic energy;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_s1 <= '0;
            in_s2 <= '0;
            lclk_d <= 1'b0;
        end else begin
            in_s1 <= {line_clk, line_data, line_energy};
            in_s2 <= in_s1;
            lclk_d <= in_s2[2];
        end
    end

    // data and clock share the same sync depth, so data is sampled at the clock rise
    assign bit_en = in_s2[2] & ~lclk_d;
    assign line_bit = in_s2[1];
    assign energy = in_s2[0];

    ////////////////////////////////////////////////////////////////////////////
    // nrzi decode and descrambler

    logic prev_line;
    logic nrz;
    logic [`FER_LFSR_W-1:0] lfsr;
    logic scr_n;
    logic ud;
    logic [6:0] match_cnt;
    logic hold_expire;
    logic strm_bit;
    logic strm_ok;
    logic strm_en;

    assign nrz = line_bit ^ prev_line;
    assign scr_n = lfsr[`FER_LFSR_TAP_A] ^ lfsr[`FER_LFSR_TAP_B];
    assign ud = nrz ^ scr_n;
    assign strm_bit = descr_bypass ? nrz : ud;
    assign strm_ok = descr_bypass | scr_locked;
    assign strm_en = bit_en & strm_ok & link_up;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_line <= 1'b0;
        end else if (bit_en) begin
            prev_line <= line_bit;
        end
    end

    // while hunting, idle means the sequence is the inverse of the nrz bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= `FER_LFSR_RST;
            match_cnt <= '0;
            scr_locked <= 1'b0;
        end else if (descr_bypass || hold_expire) begin
            lfsr <= `FER_LFSR_RST;
            match_cnt <= '0;
            scr_locked <= 1'b0;
        end else if (bit_en) begin
            if (!scr_locked) begin
                lfsr <= {lfsr[`FER_LFSR_W-2:0], ~nrz};
                if (scr_n == ~nrz) begin
                    match_cnt <= match_cnt + 1'b1;
                    scr_locked <= (match_cnt == LOCK_LAST);
                end else begin
                    match_cnt <= '0;
                end
            end else begin
                lfsr <= {lfsr[`FER_LFSR_W-2:0], scr_n};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hold timer

    logic [5:0] hold_idle;
    logic hold_hit;
    logic [HW-1:0] hold_cnt;

    assign hold_hit = bit_en & scr_locked & ud & (hold_idle == HOLD_IDLE_LAST);
    assign hold_expire = scr_locked & (hold_cnt == '0) & ~hold_hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_idle <= '0;
        end else if (!scr_locked || hold_hit) begin
            hold_idle <= '0;
        end else if (bit_en) begin
            hold_idle <= ud ? hold_idle + 1'b1 : '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= HOLD_LOAD;
        end else if (!scr_locked || hold_hit) begin
            hold_cnt <= HOLD_LOAD;
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // signal detect and link monitor

    logic [SW-1:0] sd_cnt;
    logic sig_det;
    logic [LW-1:0] lu_cnt;

    // link pulses are far shorter than the qualifying time, so they never count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_cnt <= '0;
            sig_det <= 1'b0;
        end else if (!energy) begin
            sd_cnt <= '0;
            sig_det <= 1'b0;
        end else if (sd_cnt == SIGDET_LAST) begin
            sig_det <= 1'b1;
        end else begin
            sd_cnt <= sd_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lu_cnt <= '0;
            link_up <= 1'b0;
            tx_enable <= 1'b0;
        end else if (!sig_det) begin
            lu_cnt <= '0;
            link_up <= 1'b0;
            tx_enable <= 1'b0;
        end else if (lu_cnt == LINKUP_LAST) begin
            link_up <= 1'b1;
            tx_enable <= 1'b1;
        end else begin
            lu_cnt <= lu_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alignment, frame decode and bad start detection

    fer_pkg::fer_frame_e state;
    logic [9:0] sr;
    logic [9:0] win;
    fer_pkg::fer_group_t grp;
    logic [4:0] dec;
    logic [3:0] ones_run;
    logic [2:0] bitcnt;
    logic pend_t;
    logic pend_i;
    logic pre2;
    logic fc_evt;
    logic push;
    logic [WW-1:0] push_data;
    logic push_ready;

    assign win = {sr[8:0], strm_bit};
    assign grp = win[4:0];
    assign dec = fer_dec5(grp);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr <= '0;
            ones_run <= '0;
        end else if (strm_en) begin
            sr <= win;
            if (!strm_bit) begin
                ones_run <= '0;
            end else if (ones_run != IDLE_RUN) begin
                ones_run <= ones_run + 1'b1;
            end
        end
    end

    // a word is {dv, er, nibble}; bypassed decode puts code bit 4 on er
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fer_pkg::FR_IDLE;
            bitcnt <= '0;
            pend_t <= 1'b0;
            pend_i <= 1'b0;
            pre2 <= 1'b0;
            fc_evt <= 1'b0;
            push <= 1'b0;
            push_data <= '0;
        end else begin
            push <= pre2;
            push_data <= {2'b10, `FER_NIB_PRE};
            pre2 <= 1'b0;
            fc_evt <= 1'b0;
            if (!link_up || !strm_ok) begin
                state <= fer_pkg::FR_IDLE;
                pend_t <= 1'b0;
                pend_i <= 1'b0;
            end else if (strm_en) begin
                bitcnt <= bitcnt + 1'b1;
                unique case (state)
                    fer_pkg::FR_IDLE: begin
                        if (!strm_bit && ones_run == IDLE_RUN) begin
                            state <= fer_pkg::FR_CARRIER;
                            bitcnt <= '0;
                        end
                    end
                    fer_pkg::FR_CARRIER: begin
                        if (bitcnt == TAIL_LAST) begin
                            bitcnt <= '0;
                            pend_t <= 1'b0;
                            pend_i <= 1'b0;
                            push <= 1'b1;
                            if (win == `FER_CG_JK) begin
                                state <= fer_pkg::FR_FRAME;
                                pre2 <= 1'b1;
                                push_data <= {2'b10, `FER_NIB_PRE};
                            end else begin
                                state <= fer_pkg::FR_BAD;
                                fc_evt <= 1'b1;
                                push_data <= {2'b01, `FER_NIB_BAD};
                            end
                        end
                    end
                    fer_pkg::FR_BAD: begin
                        if (bitcnt == GROUP_LAST) begin
                            bitcnt <= '0;
                            if (grp == `FER_CG_IDLE && pend_i) begin
                                state <= fer_pkg::FR_IDLE;
                            end else begin
                                pend_i <= (grp == `FER_CG_IDLE);
                                push <= 1'b1;
                                push_data <= {2'b01, `FER_NIB_BAD};
                            end
                        end
                    end
                    fer_pkg::FR_FRAME: begin
                        if (bitcnt == GROUP_LAST) begin
                            bitcnt <= '0;
                            pend_t <= (grp == `FER_CG_T);
                            pend_i <= (grp == `FER_CG_IDLE);
                            if ((pend_t && grp == `FER_CG_R) ||
                                (pend_i && grp == `FER_CG_IDLE)) begin
                                state <= fer_pkg::FR_IDLE;
                            end else if (grp != `FER_CG_T && grp != `FER_CG_IDLE) begin
                                push <= 1'b1;
                                if (dec_bypass) begin
                                    push_data <= {1'b1, grp};
                                end else if (pend_t || pend_i || !dec[4]) begin
                                    push_data <= {2'b11, `FER_NIB_BAD};
                                end else begin
                                    push_data <= {2'b10, dec[3:0]};
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, carrier sense and output stage

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            false_carrier_event_counter <= '0;
        end else if (fc_evt) begin
            false_carrier_event_counter <= false_carrier_event_counter + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crs <= 1'b0;
        end else begin
            crs <= (state != fer_pkg::FR_IDLE);
        end
    end

    // the line cannot be paused, so a full buffer drops the word and flags it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (push && !push_ready) begin
            overrun <= 1'b1;
        end
    end

    logic f_valid;
    logic [WW-1:0] f_data;
    logic f_take;

    assign f_take = f_valid & (mac_ready | ~rx_valid);

    fer_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(f_valid),
        .out_ready(mac_ready | ~rx_valid),
        .out_data(f_data)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= `FER_NIB_ZERO;
        end else if (f_take) begin
            rx_valid <= 1'b1;
            {rx_dv, rx_er, rxd} <= f_data;
        end else if (mac_ready) begin
            rx_valid <= 1'b0;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
        end
    end
endmodule

//--- testbench/fer_mac_model.sv
// nibble sink standing in for the mac
`timescale 1ns/1ps

module fer_mac_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic stall,
    input wire logic rx_valid,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    output logic mac_ready
);
    logic ph;
    logic [5:0] q[$];

    // slow takes every other clock, stall refuses all
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph <= 1'b0;
        end else begin
            ph <= ~ph;
        end
    end

    assign mac_ready = !stall && (!slow || ph);

    // bench empties q between tests
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && mac_ready === 1'b1) begin
            q.push_back({rx_dv, rx_er, rxd});
        end
    end
endmodule

//--- testbench/fer_rx_pcs_properties.sv
// port checker for the receive coding path
`timescale 1ns/1ps

module fer_rx_pcs_chk #(
    parameter int LINKUP_CYCLES = 50,
    parameter int SIGDET_CYCLES = 20,
    parameter int FCC_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_energy,
    input wire logic dec_bypass,
    input wire logic mac_ready,
    input wire logic rx_valid,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic link_up,
    input wire logic tx_enable,
    input wire logic overrun,
    input wire logic [FCC_W-1:0] false_carrier_event_counter
);
    // slack covers synchronisers and the internal reset release
    localparam int LB = LINKUP_CYCLES + SIGDET_CYCLES + 16;
    logic [15:0] ecnt;

    // saturates so a long steady link never wraps the count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ecnt <= 16'h0000;
        end else if (!line_energy) begin
            ecnt <= 16'h0000;
        end else if (ecnt < LB) begin
            ecnt <= ecnt + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    chk_tx_link: assert property (tx_enable == link_up)
        else $error("tx_enable differs from link_up");
    chk_link_qual: assert property ($rose(link_up) |-> ecnt >= LINKUP_CYCLES)
        else $error("link up too early");
    chk_link_bound: assert property (ecnt == LB |-> link_up)
        else $error("link not up under steady energy");
    chk_down_quiet: assert property (!link_up [*3] |-> !crs)
        else $error("carrier sense without link");
    chk_err_nibble: assert property (rx_valid && rx_er && !dec_bypass |-> rxd == 4'he)
        else $error("error word without 1110");
    chk_fcc_step: assert property ($changed(false_carrier_event_counter) |->
        false_carrier_event_counter - $past(false_carrier_event_counter) == FCC_W'(1))
        else $error("false carrier count step not one");
    chk_valid_hold: assert property (rx_valid && !mac_ready |=>
        rx_valid && $stable({rxd, rx_dv, rx_er}))
        else $error("word changed before taken");
    chk_idle_quiet: assert property (!rx_valid |-> !rx_dv && !rx_er)
        else $error("flags without valid word");
    chk_overrun_keep: assert property (overrun |=> overrun)
        else $error("overrun cleared");
endmodule

bind fer_rx_pcs fer_rx_pcs_chk #(
    .LINKUP_CYCLES(LINKUP_CYCLES), .SIGDET_CYCLES(SIGDET_CYCLES), .FCC_W(FCC_W)
) chk_u (
    .clk(clk), .nrst(nrst), .line_energy(line_energy), .dec_bypass(dec_bypass),
    .mac_ready(mac_ready), .rx_valid(rx_valid), .rxd(rxd), .rx_dv(rx_dv),
    .rx_er(rx_er), .crs(crs), .link_up(link_up), .tx_enable(tx_enable),
    .overrun(overrun), .false_carrier_event_counter(false_carrier_event_counter)
);

//--- testbench/fer_rx_pcs_tb_top.sv
// self-checking bench for the receive coding path
`timescale 1ns/1ps

module fer_rx_pcs_tb_top;
    logic clk = 1'b0, nrst = 1'b0, line_clk = 1'b0, line_data = 1'b0;
    logic line_energy = 1'b0, descr_bypass = 1'b0, dec_bypass = 1'b0;
    logic slow = 1'b0, stall = 1'b0, scr = 1'b0;
    logic mac_ready, rx_valid, rx_dv, rx_er, crs, link_up, tx_en, locked, overrun;
    logic [3:0] rxd;
    logic [15:0] fcc;
    logic [10:0] lf = 11'h05a5;
    logic [5:0] want[$];
    logic [4:0] gs[$];
    logic [4:0] code[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    int errors = 0, n_tests = 0, cyc = 0;

    always #50 clk = ~clk;

    fer_rx_pcs #(.HOLD_CYCLES(1200), .LINKUP_CYCLES(50)) dut_u (
        .clk(clk), .nrst(nrst), .line_clk(line_clk), .line_data(line_data),
        .line_energy(line_energy), .descr_bypass(descr_bypass), .dec_bypass(dec_bypass),
        .mac_ready(mac_ready), .rx_valid(rx_valid), .rxd(rxd), .rx_dv(rx_dv),
        .rx_er(rx_er), .crs(crs), .link_up(link_up), .tx_enable(tx_en),
        .scr_locked(locked), .overrun(overrun), .false_carrier_event_counter(fcc));

    fer_mac_model mac_u (.clk(clk), .nrst(nrst), .slow(slow), .stall(stall),
        .rx_valid(rx_valid), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .mac_ready(mac_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // data moves while the line clock is low
    task automatic bit_out(input logic b);
        logic n;
        n = lf[10] ^ lf[8];
        if (scr) begin
            lf = {lf[9:0], n};
            b = b ^ n;
        end
        @(posedge clk);
        line_clk <= 1'b0;
        if (b) line_data <= ~line_data;
        repeat (4) @(posedge clk);
        line_clk <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic send();
        foreach (gs[i]) for (int k = 4; k >= 0; k--) bit_out(gs[i][k]);
    endtask

    task automatic idles(input int n);
        gs = '{};
        repeat (n) gs.push_back(5'h1f);
        send();
    endtask

    task automatic chk_q(input string nm);
        cmp(nm, want.size(), mac_u.q.size());
        foreach (want[i]) cmp(nm, want[i], mac_u.q[i]);
        mac_u.q.delete();
    endtask

    task automatic table_frame();
        gs = '{5'h18, 5'h11};
        want = '{6'h25, 6'h25};
        foreach (code[i]) begin
            gs.push_back(code[i]);
            want.push_back({2'b10, 4'(i)});
        end
        gs.push_back(5'h0d);
        gs.push_back(5'h07);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_link();
        int k;
        repeat (8) begin
            @(posedge clk);
            line_energy <= 1'b1;
            repeat (5) @(posedge clk);
            line_energy <= 1'b0;
            repeat (30) @(posedge clk);
        end
        cmp("link on pulses", 0, link_up);
        @(posedge clk);
        line_energy <= 1'b1;
        for (k = 0; k < 300 && link_up !== 1'b1; k++) @(posedge clk);
        cmp("link delay", 1, k >= 50);
        cmp("link_up", 1, link_up);
        cmp("tx_enable", 1, tx_en);
        $display("test link done");
    endtask

    task automatic t_scr();
        scr = 1'b1;
        idles(6);
        cmp("early lock", 0, locked);
        idles(14);
        cmp("lock", 1, locked);
        mac_u.q.delete();
        gs = '{5'h18, 5'h11, 5'h1e, 5'h09, 5'h14, 5'h15, 5'h0d, 5'h07};
        want = '{6'h25, 6'h25, 6'h20, 6'h21, 6'h22, 6'h23};
        send();
        idles(4);
        chk_q("scrambled frame");
        idles(30);
        cmp("lock held", 1, locked);
        gs = '{5'h18, 5'h11};
        repeat (34) gs.push_back(5'h14);
        send();
        cmp("lock dropped", 0, locked);
        scr = 1'b0;
        $display("test scrambler done");
    endtask

    task automatic t_table();
        @(posedge clk);
        descr_bypass <= 1'b1;
        slow <= 1'b1;
        idles(4);
        mac_u.q.delete();
        table_frame();
        send();
        idles(4);
        chk_q("decode table");
        $display("test table done");
    endtask

    task automatic t_bad();
        logic [15:0] c0;
        c0 = fcc;
        gs = '{5'h14, 5'h14};
        send();
        cmp("crs false carrier", 1, crs);
        gs = '{5'h14};
        send();
        idles(4);
        cmp("false carriers", c0 + 16'h0001, fcc);
        cmp("crs after idles", 0, crs);
        cmp("error words", 1, mac_u.q.size() >= 3);
        foreach (mac_u.q[i]) cmp("error word", 6'h1e, mac_u.q[i]);
        mac_u.q.delete();
        $display("test bad start done");
    endtask

    task automatic t_ctrl();
        gs = '{5'h18, 5'h11, 5'h0b, 5'h18, 5'h0f, 5'h0d, 5'h07};
        want = '{6'h25, 6'h25, 6'h25, 6'h3e, 6'h27};
        send();
        idles(4);
        chk_q("invalid in frame");
        $display("test control done");
    endtask

    task automatic t_raw();
        dec_bypass <= 1'b1;
        gs = '{5'h18, 5'h11, 5'h0b, 5'h04, 5'h1e, 5'h0d, 5'h07};
        want = '{6'h25, 6'h25, 6'h2b, 6'h24, 6'h3e};
        send();
        idles(4);
        chk_q("raw groups");
        dec_bypass <= 1'b0;
        $display("test raw done");
    endtask

    task automatic t_fill();
        @(posedge clk);
        stall <= 1'b1;
        table_frame();
        send();
        idles(1);
        cmp("overrun", 1, overrun);
        @(posedge clk);
        stall <= 1'b0;
        idles(4);
        cmp("kept words", 1, mac_u.q.size() >= 8 && mac_u.q.size() < 18);
        cmp("first kept", 6'h25, mac_u.q[0]);
        $display("test fill done");
    endtask

    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("reset link", 0, link_up);
        cmp("reset outputs", 0, {rx_valid, crs, overrun, locked});
        cmp("reset counter", 0, fcc);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("released", 0, {link_up, rx_valid, crs, locked});
        $display("test reset done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // all tests need about 8000 clocks
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("CHECK FAILED timeout exp end got hang");
            close_out();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_link();
        t_scr();
        t_table();
        t_bad();
        t_ctrl();
        t_raw();
        t_fill();
        t_reset();
        close_out();
    end
endmodule
